// file: rtl/shs_pkg.sv
// constants, types and register map of the servo homing sequencer
package shs_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_MODE_DISP = 8'h08;
    localparam logic [7:0] OFF_METHOD = 8'h0C;
    localparam logic [7:0] OFF_SPD_FAST = 8'h10;
    localparam logic [7:0] OFF_SPD_SLOW = 8'h14;
    localparam logic [7:0] OFF_ACCEL = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_HOME_POS = 8'h20;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_BIT = 4;
    localparam int STAT_REACHED_BIT = 10;
    localparam int STAT_ATTAINED_BIT = 12;
    localparam int STAT_ERROR_BIT = 13;
    localparam int STAT_READY_BIT = 15;

    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_METHOD = 8'h00;
    localparam logic [31:0] RST_SPEED = 32'h00000000;
    localparam logic [31:0] RST_ACCEL = 32'h00000000;

    localparam logic [7:0] MODE_HOMING = 8'h06;
    localparam logic [7:0] METH_SEEK_A_POS = 8'h08;
    localparam logic [7:0] METH_SEEK_B_POS = 8'h09;
    localparam logic [7:0] METH_SEEK_C_POS = 8'h0A;
    localparam logic [7:0] METH_SEEK_D_NEG = 8'h0B;
    localparam logic [7:0] METH_SEEK_A_NEG = 8'h0C;
    localparam logic [7:0] METH_SEEK_B_NEG = 8'h0D;
    localparam logic [7:0] METH_SEEK_C_NEG = 8'h0E;
    localparam logic [7:0] METH_MAP_LO = 8'h11;
    localparam logic [7:0] METH_MAP_HI = 8'h1E;
    localparam logic [7:0] METH_MAP_SHIFT = 8'h10;
    localparam logic [7:0] METH_INDEX_NEG = 8'h21;
    localparam logic [7:0] METH_INDEX_POS = 8'h22;
    localparam logic [7:0] METH_SET_A = 8'h23;
    localparam logic [7:0] METH_SET_B = 8'h25;

    typedef enum logic [2:0] {
        SHS_IDLE = 3'b000,
        SHS_FAST = 3'b001,
        SHS_SLOW = 3'b010,
        SHS_INDEX = 3'b011,
        SHS_DONE = 3'b100,
        SHS_ERR = 3'b101
    } shs_state_e;

    // search shape shared by each mirrored pair of methods; SHS_VAR_D serves METH_SEEK_D_NEG alone
    typedef enum logic [1:0] {
        SHS_VAR_A = 2'b00,
        SHS_VAR_B = 2'b01,
        SHS_VAR_C = 2'b10,
        SHS_VAR_D = 2'b11
    } shs_var_e;

    typedef struct packed {
        logic lim_pos;
        logic lim_neg;
        logic home_sw;
        logic index;
    } shs_sense_s;
endpackage : shs_pkg

// file: rtl/shs_ramp.sv
// acceleration limited speed ramp with immediate halt
`timescale 1ns/100ps
module shs_ramp #(
    parameter int W = 33
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic signed [W-1:0] target,
    input wire logic [W-2:0] step,
    input wire logic halt,
    output logic signed [W-1:0] speed,
    output logic at_target
);
    logic signed [W:0] diff;
    logic signed [W:0] step_ext;

    assign diff = {target[W-1], target} - {speed[W-1], speed};
    assign step_ext = $signed({2'b00, step});
    assign at_target = (speed == target);

    // zero step means no ramp: the command jumps to its target
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            speed <= '0;
        end else if (halt) begin
            speed <= '0;
        end else if (step == '0 || (diff <= step_ext && diff >= -step_ext)) begin
            speed <= target;
        end else if (diff > 0) begin
            speed <= speed + step_ext[W-1:0];
        end else begin
            speed <= speed - step_ext[W-1:0];
        end
    end
endmodule : shs_ramp

// file: rtl/shs_sequencer.sv
// homing sequencer with APB register file and speed command output
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module shs_sequencer #(
    parameter int POS_W = 32
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input shs_pkg::shs_sense_s sense,
    input wire logic [POS_W-1:0] act_pos,
    output logic signed [32:0] speed_cmd
);
    logic [15:0] ctrl;
    logic [7:0] mode;
    logic [7:0] mode_disp;
    logic [7:0] method;
    logic [31:0] spd_fast;
    logic [31:0] spd_slow;
    logic [31:0] accel;
    logic [POS_W-1:0] home_pos;
    logic err_flag;
    logic start_prev;
    shs_pkg::shs_state_e st;
    shs_pkg::shs_var_e var_q;
    logic seek_neg;
    logic dir_neg;
    logic fast_exit;
    logic fast_seen;
    logic slow_tgt;
    logic armed;

    logic wr;
    logic start_edge;
    logic busy;
    logic enabled;
    logic [7:0] base;
    logic err_evt;
    logic start_err;
    logic set_here;
    logic abort;
    logic seek_lim;
    logic bad_lim;
    logic signed [32:0] target;
    logic at_target;
    logic hs;

    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            shs_pkg::OFF_CTRL, shs_pkg::OFF_MODE, shs_pkg::OFF_MODE_DISP,
            shs_pkg::OFF_METHOD, shs_pkg::OFF_SPD_FAST, shs_pkg::OFF_SPD_SLOW,
            shs_pkg::OFF_ACCEL, shs_pkg::OFF_STATUS, shs_pkg::OFF_HOME_POS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // methods 17 to 30 fold onto 1 to 14
    function automatic logic [7:0] map_method(input logic [7:0] m);
        if (m >= shs_pkg::METH_MAP_LO && m <= shs_pkg::METH_MAP_HI) begin
            map_method = m - shs_pkg::METH_MAP_SHIFT;
        end else begin
            map_method = m;
        end
    endfunction : map_method

    function automatic logic is_switch_method(input logic [7:0] m);
        is_switch_method = (m >= shs_pkg::METH_SEEK_A_POS && m <= shs_pkg::METH_SEEK_C_NEG);
    endfunction : is_switch_method

    function automatic shs_pkg::shs_var_e var_of(input logic [7:0] m);
        case (m)
            shs_pkg::METH_SEEK_A_POS, shs_pkg::METH_SEEK_A_NEG: var_of = shs_pkg::SHS_VAR_A;
            shs_pkg::METH_SEEK_B_POS, shs_pkg::METH_SEEK_B_NEG: var_of = shs_pkg::SHS_VAR_B;
            shs_pkg::METH_SEEK_C_POS, shs_pkg::METH_SEEK_C_NEG: var_of = shs_pkg::SHS_VAR_C;
            default: var_of = shs_pkg::SHS_VAR_D;
        endcase
    endfunction : var_of

    function automatic logic [15:0] status_word(input logic ready, input logic err,
                                                input logic attained, input logic reached);
        status_word = '0;
        status_word[shs_pkg::STAT_READY_BIT] = ready;
        status_word[shs_pkg::STAT_ERROR_BIT] = err;
        status_word[shs_pkg::STAT_ATTAINED_BIT] = attained;
        status_word[shs_pkg::STAT_REACHED_BIT] = reached;
    endfunction : status_word

    // bus: no wait states, unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign wr = psel && penable && pwrite && addr_hit(paddr);

    assign hs = sense.home_sw;
    assign enabled = ctrl[shs_pkg::CTRL_ENABLE_BIT];
    assign start_edge = ctrl[shs_pkg::CTRL_START_BIT] && !start_prev;
    assign busy = (st == shs_pkg::SHS_FAST) || (st == shs_pkg::SHS_SLOW) || (st == shs_pkg::SHS_INDEX);
    assign base = map_method(method);

    // the limit on the search side reverses; the far one is forbidden
    assign seek_lim = seek_neg ? sense.lim_neg : sense.lim_pos;
    assign bad_lim = seek_neg ? sense.lim_pos : sense.lim_neg;

    assign set_here = start_edge && !busy && mode_disp == shs_pkg::MODE_HOMING
        && (base == shs_pkg::METH_SET_A || base == shs_pkg::METH_SET_B);
    assign start_err = start_edge && !busy && enabled && mode_disp == shs_pkg::MODE_HOMING
        && !set_here && !is_switch_method(base)
        && base != shs_pkg::METH_INDEX_NEG && base != shs_pkg::METH_INDEX_POS;

    always_comb begin
        err_evt = 1'b0;
        if (st == shs_pkg::SHS_INDEX) begin
            err_evt = sense.lim_pos || sense.lim_neg || hs;
        end else if (st == shs_pkg::SHS_FAST || st == shs_pkg::SHS_SLOW) begin
            err_evt = bad_lim;
        end
    end

    assign abort = busy && (!enabled || mode_disp != shs_pkg::MODE_HOMING);

    // register writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= shs_pkg::RST_CTRL;
            mode <= shs_pkg::RST_MODE;
            method <= shs_pkg::RST_METHOD;
            spd_fast <= shs_pkg::RST_SPEED;
            spd_slow <= shs_pkg::RST_SPEED;
            accel <= shs_pkg::RST_ACCEL;
        end else if (wr) begin
            case (paddr)
                shs_pkg::OFF_CTRL: ctrl <= pwdata[15:0];
                shs_pkg::OFF_MODE: mode <= pwdata[7:0];
                shs_pkg::OFF_METHOD: method <= pwdata[7:0];
                shs_pkg::OFF_SPD_FAST: spd_fast <= pwdata;
                shs_pkg::OFF_SPD_SLOW: spd_slow <= pwdata;
                shs_pkg::OFF_ACCEL: accel <= pwdata;
                default: ;
            endcase
        end
    end

    // displayed mode follows the requested mode one cycle later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_disp <= shs_pkg::RST_MODE;
            start_prev <= 1'b0;
        end else begin
            mode_disp <= mode;
            start_prev <= ctrl[shs_pkg::CTRL_START_BIT];
        end
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                shs_pkg::OFF_CTRL: prdata <= {16'h0000, ctrl};
                shs_pkg::OFF_MODE: prdata <= {24'h000000, mode};
                shs_pkg::OFF_MODE_DISP: prdata <= {24'h000000, mode_disp};
                shs_pkg::OFF_METHOD: prdata <= {24'h000000, method};
                shs_pkg::OFF_SPD_FAST: prdata <= spd_fast;
                shs_pkg::OFF_SPD_SLOW: prdata <= spd_slow;
                shs_pkg::OFF_ACCEL: prdata <= accel;
                shs_pkg::OFF_STATUS: prdata <= {16'h0000, status_word(!busy, err_flag,
                    st == shs_pkg::SHS_DONE, st == shs_pkg::SHS_DONE && at_target)};
                shs_pkg::OFF_HOME_POS: prdata <= 32'(home_pos);
                default: prdata <= '0;
            endcase
        end
    end

    // error flag: a new start clears it, but a fresh error in that cycle wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            err_flag <= 1'b0;
        end else begin
            err_flag <= err_evt || start_err || (err_flag && !(start_edge && !busy));
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            home_pos <= '0;
        end else if (set_here) begin
            home_pos <= act_pos;
        end
    end

    // search sequencing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= shs_pkg::SHS_IDLE;
            var_q <= shs_pkg::SHS_VAR_A;
            seek_neg <= 1'b0;
            dir_neg <= 1'b0;
            fast_exit <= 1'b0;
            fast_seen <= 1'b0;
            slow_tgt <= 1'b0;
            armed <= 1'b0;
        end else if (!busy) begin
            if (set_here) begin
                st <= shs_pkg::SHS_DONE;
            end else if (start_err) begin
                st <= shs_pkg::SHS_ERR;
            end else if (start_edge && enabled && mode_disp == shs_pkg::MODE_HOMING) begin
                var_q <= var_of(base);
                seek_neg <= base >= shs_pkg::METH_SEEK_D_NEG;
                if (base == shs_pkg::METH_INDEX_NEG) begin
                    st <= shs_pkg::SHS_INDEX;
                    dir_neg <= 1'b1;
                end else if (base == shs_pkg::METH_INDEX_POS) begin
                    st <= shs_pkg::SHS_INDEX;
                    dir_neg <= 1'b0;
                end else begin
                    case (var_of(base))
                        shs_pkg::SHS_VAR_A: begin
                            // starting on the switch: leave it fast against the search
                            st <= hs ? shs_pkg::SHS_FAST : shs_pkg::SHS_SLOW;
                            dir_neg <= hs ? (base < shs_pkg::METH_SEEK_D_NEG) : (base >= shs_pkg::METH_SEEK_D_NEG);
                            fast_exit <= 1'b0;
                            fast_seen <= 1'b1;
                            slow_tgt <= 1'b1;
                            armed <= 1'b1;
                        end
                        shs_pkg::SHS_VAR_B: begin
                            st <= shs_pkg::SHS_FAST;
                            dir_neg <= base >= shs_pkg::METH_SEEK_D_NEG;
                            fast_exit <= 1'b0;
                            fast_seen <= hs;
                        end
                        shs_pkg::SHS_VAR_C: begin
                            st <= shs_pkg::SHS_SLOW;
                            dir_neg <= base >= shs_pkg::METH_SEEK_D_NEG;
                            slow_tgt <= 1'b0;
                            armed <= hs;
                        end
                        default: begin
                            st <= hs ? shs_pkg::SHS_SLOW : shs_pkg::SHS_FAST;
                            dir_neg <= !hs;
                            fast_exit <= 1'b1;
                            fast_seen <= 1'b1;
                            slow_tgt <= 1'b0;
                            armed <= 1'b1;
                        end
                    endcase
                end
            end
        end else if (err_evt) begin
            st <= shs_pkg::SHS_ERR;
        end else if (abort) begin
            st <= shs_pkg::SHS_IDLE;
        end else begin
            case (st)
                shs_pkg::SHS_FAST: begin
                    if (hs != fast_exit) begin
                        fast_seen <= 1'b1;
                    end
                    // a switch edge, or the search-side limit while heading to it
                    if ((hs == fast_exit && fast_seen) || (seek_lim && dir_neg == seek_neg)) begin
                        st <= shs_pkg::SHS_SLOW;
                        dir_neg <= !dir_neg;
                        slow_tgt <= (var_q == shs_pkg::SHS_VAR_A || var_q == shs_pkg::SHS_VAR_B);
                        armed <= hs != (var_q == shs_pkg::SHS_VAR_A || var_q == shs_pkg::SHS_VAR_B);
                    end
                end
                shs_pkg::SHS_SLOW: begin
                    if (hs != slow_tgt) begin
                        armed <= 1'b1;
                    end
                    if (armed && hs == slow_tgt && sense.index) begin
                        st <= shs_pkg::SHS_DONE;
                    end else if (seek_lim && dir_neg == seek_neg
                                 && (var_q == shs_pkg::SHS_VAR_A || var_q == shs_pkg::SHS_VAR_C)) begin
                        st <= shs_pkg::SHS_FAST;
                        dir_neg <= !dir_neg;
                        fast_exit <= var_q == shs_pkg::SHS_VAR_C;
                        fast_seen <= hs != (var_q == shs_pkg::SHS_VAR_C);
                    end
                end
                shs_pkg::SHS_INDEX: begin
                    if (sense.index) begin
                        st <= shs_pkg::SHS_DONE;
                    end
                end
                default: st <= shs_pkg::SHS_IDLE;
            endcase
        end
    end

    always_comb begin
        case (st)
            shs_pkg::SHS_FAST: target = dir_neg ? -$signed({1'b0, spd_fast}) : $signed({1'b0, spd_fast});
            shs_pkg::SHS_SLOW, shs_pkg::SHS_INDEX:
                target = dir_neg ? -$signed({1'b0, spd_slow}) : $signed({1'b0, spd_slow});
            default: target = '0;
        endcase
    end

    // errors stop at once; normal stops and reversals follow the ramp
    shs_ramp #(
        .W(33)
    ) u_ramp (
        .mclk(mclk),
        .nrst(nrst),
        .target(target),
        .step(accel),
        .halt(err_evt || st == shs_pkg::SHS_ERR),
        .speed(speed_cmd),
        .at_target(at_target)
    );
endmodule : shs_sequencer

// file: tb/servo_homing_sequencer_test.sv
// self-checking bench for the homing sequencer
`timescale 1ns/100ps
module servo_homing_sequencer_test;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    shs_pkg::shs_sense_s sense;
    logic signed [31:0] pos;
    logic signed [32:0] speed_cmd;
    logic load = 1'b0;
    logic [31:0] load_pos = 32'h00000000;
    int err_total = 0;
    int compares = 0;

    always #50 mclk = ~mclk;

    shs_sequencer u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense), .act_pos(pos),
        .speed_cmd(speed_cmd));
    shs_axis_model u_axis (.mclk(mclk), .nrst(nrst), .speed(speed_cmd), .load(load), .load_pos(load_pos),
        .sense(sense), .pos(pos));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // entered just after a rising edge, leaves one idle edge behind it
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        apb(1'b1, addr, data, d);
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        apb(1'b0, addr, 32'h00000000, d);
        chk(d, exp);
    endtask : rd

    task automatic place(input logic [31:0] p);
        load <= 1'b1;
        load_pos <= p;
        @(posedge mclk);
        load <= 1'b0;
    endtask : place

    task automatic run(input logic [7:0] meth, input logic [31:0] p0, input logic [31:0] ctl);
        place(p0);
        wr(shs_pkg::OFF_METHOD, {24'h000000, meth});
        wr(shs_pkg::OFF_CTRL, ctl & 32'hFFFFFFEF);
        wr(shs_pkg::OFF_CTRL, ctl);
    endtask : run

    task automatic finish_run(input logic [31:0] exp_st);
        int n;
        logic [31:0] s;
        n = 0;
        s = 32'h00000000;
        while (s[10] !== 1'b1 && s[13] !== 1'b1 && n < 3000) begin
            apb(1'b0, shs_pkg::OFF_STATUS, 32'h00000000, s);
            n++;
        end
        chk(s & 32'h00003400, exp_st);
        chk(speed_cmd[31:0], 32'h00000000);
        wr(shs_pkg::OFF_CTRL, 32'h00000001);
    endtask : finish_run

    // jump the axis onto a forbidden switch mid-search, so the halt is seen with the motor moving
    task automatic trip(input logic [31:0] p);
        repeat (12) @(posedge mclk);
        place(p);
        finish_run(32'h00002000);
    endtask : trip

    task automatic home(input logic [7:0] meth, input logic [31:0] p0, input logic hs_exp, input logic [31:0] blk);
        run(meth, p0, 32'h00000011);
        finish_run(32'h00001400);
        chk(sense.home_sw, hs_exp);
        chk({8'h00, pos[31:8]}, blk);
    endtask : home

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #5000000;
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(shs_pkg::OFF_CTRL, 32'h00000000);
        rd(shs_pkg::OFF_METHOD, 32'h00000000);
        rd(8'h24, 32'h00000000);
        chk(last_err, 1'b1);
        wr(shs_pkg::OFF_SPD_FAST, 32'h00000010);
        wr(shs_pkg::OFF_SPD_SLOW, 32'h00000004);
        wr(shs_pkg::OFF_ACCEL, 32'h00000002);
        rd(shs_pkg::OFF_SPD_SLOW, 32'h00000004);
        wr(shs_pkg::OFF_MODE, 32'h00000001);
        run(shs_pkg::METH_INDEX_POS, 32'h00000064, 32'h00000011);
        repeat (20) @(posedge mclk);
        chk(speed_cmd[31:0], 32'h00000000);
        wr(shs_pkg::OFF_MODE, 32'h00000006);
        rd(shs_pkg::OFF_MODE_DISP, 32'h00000006);
        $display("test registers done");
        run(shs_pkg::METH_INDEX_POS, 32'h00000064, 32'h00000011);
        finish_run(32'h00001400);
        chk({8'h00, pos[31:8]}, 32'h00000001);
        run(shs_pkg::METH_INDEX_NEG, 32'h00000064, 32'h00000011);
        finish_run(32'h00001400);
        chk({8'h00, pos[31:8]}, 32'h00FFFFFF);
        $display("test index methods done");
        run(shs_pkg::METH_SEEK_A_POS, 32'h00000000, 32'h00000011);
        repeat (12) @(posedge mclk);
        chk(speed_cmd[31:0], 32'h00000004);
        finish_run(32'h00001400);
        chk(sense.home_sw, 1'b1);
        chk({8'h00, pos[31:8]}, 32'h00000004);
        run(8'h18, 32'h000004B0, 32'h00000011);
        repeat (12) @(posedge mclk);
        chk(speed_cmd[31:0], 32'hFFFFFFF0);
        finish_run(32'h00001400);
        chk(sense.home_sw, 1'b1);
        home(shs_pkg::METH_SEEK_A_POS, 32'h00000F3C, 1'b1, 32'h00000004);
        home(shs_pkg::METH_SEEK_B_POS, 32'h00000000, 1'b1, 32'h00000004);
        home(shs_pkg::METH_SEEK_C_POS, 32'h00000000, 1'b0, 32'h00000006);
        home(shs_pkg::METH_SEEK_D_NEG, 32'h000007D0, 1'b0, 32'h00000006);
        home(shs_pkg::METH_SEEK_A_NEG, 32'h000004B0, 1'b1, 32'h00000004);
        home(shs_pkg::METH_SEEK_B_NEG, 32'h00000000, 1'b1, 32'h00000004);
        home(shs_pkg::METH_SEEK_C_NEG, 32'h00000000, 1'b0, 32'h00000002);
        $display("test switch methods done");
        run(shs_pkg::METH_SEEK_A_NEG, 32'h00000000, 32'h00000011);
        trip(32'h00001004);
        run(shs_pkg::METH_SEEK_B_POS, 32'h00000000, 32'h00000011);
        trip(32'hFFFFEFFC);
        run(shs_pkg::METH_INDEX_NEG, 32'h00000064, 32'h00000011);
        trip(32'h000004B0);
        $display("test homing errors done");
        for (int i = 0; i < 2; i++) begin
            run(i == 0 ? shs_pkg::METH_SET_A : shs_pkg::METH_SET_B, 32'h00001234 + i, 32'h00000010);
            finish_run(32'h00001400);
            rd(shs_pkg::OFF_HOME_POS, 32'h00001234 + i);
        end
        $display("test set position done");
        give_verdict();
    end
endmodule : servo_homing_sequencer_test

// file: tb/shs_axis_model.sv
// axis model: integrates the speed command and derives switches and index
`timescale 1ns/100ps
module shs_axis_model #(
    parameter int HOME_LO = 1000,
    parameter int HOME_HI = 1400,
    parameter int LIM = 4000
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic signed [32:0] speed,
    input wire logic load,
    input wire logic signed [31:0] load_pos,
    output shs_pkg::shs_sense_s sense,
    output logic signed [31:0] pos
);
    logic signed [31:0] nxt;
    logic idx;
    assign nxt = load ? load_pos : pos + speed[31:0];
    // one index per 256 counts, so several pulses pass before the switch is reached
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pos <= '0;
            idx <= 1'b0;
        end else begin
            pos <= nxt;
            idx <= !load && nxt[31:8] != pos[31:8];
        end
    end
    assign sense = '{lim_pos: pos >= LIM, lim_neg: pos <= -LIM, home_sw: pos >= HOME_LO && pos <= HOME_HI,
                     index: idx};
endmodule : shs_axis_model

// file: tb/shs_sequencer_assertions.sv
// port checker for the homing sequencer
`timescale 1ns/100ps
module shs_sequencer_assertions #(
    parameter int POS_W = 32
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input shs_pkg::shs_sense_s sense,
    input wire logic [POS_W-1:0] act_pos,
    input wire logic signed [32:0] speed_cmd
);
    logic [7:0] meth;
    logic acc;
    logic unmapped;
    logic m8_10;
    logic m11_14;
    logic m_idx;
    logic m_set;
    assign acc = psel && penable;
    assign unmapped = paddr > 8'h20 || paddr[1:0] != 2'b00;
    assign m8_10 = meth inside {[8'h08:8'h0A], [8'h18:8'h1A]};
    assign m11_14 = meth inside {[8'h0B:8'h0E], [8'h1B:8'h1E]};
    assign m_idx = meth == 8'h21 || meth == 8'h22;
    assign m_set = meth == 8'h23 || meth == 8'h25;
    // shadow of the method register, taken at the same edge the slave takes writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meth <= 8'h00;
        end else if (acc && pwrite && paddr == 8'h0C) begin
            meth <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_err_phase;
        pslverr |-> acc;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access phase");
    property p_unmapped;
        acc && unmapped |-> pslverr && (pwrite || prdata == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped;
        acc && !unmapped |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_neg_lim;
        m8_10 && sense.lim_neg && speed_cmd != 0 |=> speed_cmd == 0;
    endproperty
    a_neg_lim: assert property (p_neg_lim) else $error("negative limit did not halt");
    property p_pos_lim;
        m11_14 && sense.lim_pos && speed_cmd != 0 |=> speed_cmd == 0;
    endproperty
    a_pos_lim: assert property (p_pos_lim) else $error("positive limit did not halt");
    property p_idx_err;
        m_idx && (sense.lim_pos || sense.lim_neg || sense.home_sw) && speed_cmd != 0 |=> speed_cmd == 0;
    endproperty
    a_idx_err: assert property (p_idx_err) else $error("switch in index search did not halt");
    property p_dir_neg;
        meth == 8'h21 && speed_cmd != 0 |-> speed_cmd < 0;
    endproperty
    a_dir_neg: assert property (p_dir_neg) else $error("index search moved positive");
    property p_dir_pos;
        meth == 8'h22 && speed_cmd != 0 |-> speed_cmd > 0;
    endproperty
    a_dir_pos: assert property (p_dir_pos) else $error("index search moved negative");
    property p_set;
        acc && pwrite && paddr == 8'h00 && pwdata[4] && m_set && speed_cmd == 0 |=> (speed_cmd == 0) [*4];
    endproperty
    a_set: assert property (p_set) else $error("set-position method moved");
endmodule : shs_sequencer_assertions

bind shs_sequencer shs_sequencer_assertions #(.POS_W(POS_W)) u_chk (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .act_pos(act_pos), .speed_cmd(speed_cmd));
